// ===== logic/crs_operand_ext.sv
// operand extension and alignment check of the register set
// assumes purely combinational use on the core clock
`timescale 1ns/1ps
module crs_operand_ext (
  input wire crs_pkg::crs_wkind_t kind,
  input wire crs_pkg::crs_size_t size,
  input wire crs_pkg::crs_imm_op_t imm_op,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  input wire logic chk_en,
  input wire logic [31:0] chk_addr,
  input wire crs_pkg::crs_size_t chk_size,
  input wire logic chk_stack,
  output logic align_err
);

  // ==========================================================
  // register write data, always a full longword
  always_comb begin
    data_out = data_in;
    if (kind == crs_pkg::WK_LOAD) begin
      if (size == crs_pkg::SZ_BYTE) begin
        data_out = {{24{data_in[7]}}, data_in[7:0]};
      end else if (size == crs_pkg::SZ_WORD) begin
        data_out = {{16{data_in[15]}}, data_in[15:0]};
      end
    end else if (kind == crs_pkg::WK_IMM) begin
      // byte field of the instruction code only
      if (imm_op == crs_pkg::IM_MOVE || imm_op == crs_pkg::IM_ADD ||
          imm_op == crs_pkg::IM_COMPARE_EQUAL) begin
        data_out = {{24{data_in[7]}}, data_in[7:0]};
      end else begin
        data_out = {24'h00_0000, data_in[7:0]};
      end
    end
  end

  // ==========================================================
  // alignment: stack is always longword whatever size is asked
  always_comb begin
    align_err = 1'b0;
    if (chk_en) begin
      if (chk_stack) begin
        align_err = |chk_addr[1:0];
      end else if (chk_size == crs_pkg::SZ_WORD) begin
        align_err = chk_addr[0];
      end else if (chk_size == crs_pkg::SZ_LONG) begin
        align_err = |chk_addr[1:0];
      end
      // bytes never fault
    end
  end

endmodule

// ===== logic/crs_pkg.sv
// shared constants and types of the processor register set
// assumes a 32-bit apb slave map with one aligned word per register
package crs_pkg;

  // ==========================================================
  // apb register map (byte addresses)
  localparam logic [7:0] OFS_GR_BASE = 8'h00;
  localparam logic [7:0] OFS_STATE_WORD = 8'h40;
  localparam logic [7:0] OFS_GLOBAL_BASE = 8'h44;
  localparam logic [7:0] OFS_VEC_BASE = 8'h48;
  localparam logic [7:0] OFS_MAC_HIGH = 8'h4c;
  localparam logic [7:0] OFS_MAC_LOW = 8'h50;
  localparam logic [7:0] OFS_RETURN_LINK = 8'h54;
  localparam logic [7:0] OFS_INSTR_PTR = 8'h58;
  localparam logic [7:0] OFS_STATUS = 8'h5c;

  // ==========================================================
  // processor state word layout
  localparam int T_BIT = 0;
  localparam int MASK_LSB = 4;
  localparam int MASK_MSB = 7;
  localparam logic [31:0] STATE_WRITABLE = 32'h0000_03f3;
  localparam logic [31:0] STATE_RESET = 32'h0000_00f0;
  localparam logic [31:0] VEC_BASE_RESET = 32'h0000_0000;

  // status register bits
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_AERR_BIT = 1;

  // vector table entries relative to the vector base, then stack step and pc-relative offset
  localparam logic [31:0] VT_IP_ENTRY = 32'h0000_0000;
  localparam logic [31:0] VT_STACK_ENTRY = 32'h0000_0004;
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;
  localparam logic [31:0] IP_AHEAD = 32'h0000_0004;

  // ==========================================================
  // operand types
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} crs_size_t;
  typedef enum logic [1:0] {WK_FULL, WK_LOAD, WK_IMM} crs_wkind_t;
  typedef enum logic [2:0] {
    IM_MOVE, IM_ADD, IM_COMPARE_EQUAL, IM_TEST_AND_FLAG, IM_AND, IM_OR, IM_XOR
  } crs_imm_op_t;
  typedef enum logic [2:0] {
    CS_STATE_WORD, CS_GLOBAL_BASE, CS_VEC_BASE, CS_MAC_HIGH, CS_MAC_LOW,
    CS_RETURN_LINK, CS_INSTR_PTR
  } crs_ctl_sel_t;

endpackage

// ===== logic/crs_register_set.sv
// processor register set: general, control and system registers,
// reset load from the vector table, apb access for software
// assumes the pipeline and memory unit run on pclk and wait for run
`timescale 1ns/1ps

// Function
// - sixteen 32-bit general registers
// - register zero is the index register
// - register fifteen is the exception stack pointer
// - global base for indirect peripheral addressing
// - vector base forms exception vector addresses
// - multiply-accumulate high and low registers
// - return link holds subroutine return address
// - reset loads stack pointer from vector table
// - reset loads instruction pointer, then fetching starts
// - reset sets mask bits, clears reserved bits
// - register operands are always full longwords
// - byte and word loads are sign-extended
// - byte accesses never raise alignment errors
// - misaligned word or longword raises address error
// - stack transfers are aligned longwords
// - byte immediates come from instruction field
// - move, add, compare immediates sign-extended
// - test, and, or, xor immediates zero-extended
// - wider immediates read pc-relative from memory
module crs_register_set (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic vt_req,
  output logic [31:0] vt_addr,
  input wire logic vt_ack,
  input wire logic [31:0] vt_data,
  output logic run,
  input wire logic [3:0] rd_a_idx,
  input wire logic [3:0] rd_b_idx,
  output logic [31:0] rd_a_data,
  output logic [31:0] rd_b_data,
  input wire logic gr_wr_en,
  input wire logic [3:0] gr_wr_idx,
  input wire crs_pkg::crs_wkind_t gr_wr_kind,
  input wire crs_pkg::crs_size_t gr_wr_size,
  input wire crs_pkg::crs_imm_op_t gr_wr_imm_op,
  input wire logic [31:0] gr_wr_data,
  input wire logic ctl_wr_en,
  input wire crs_pkg::crs_ctl_sel_t ctl_wr_sel,
  input wire logic [31:0] ctl_wr_data,
  input wire logic mac_wr_en,
  input wire logic [31:0] mac_high_data,
  input wire logic [31:0] mac_low_data,
  input wire logic call_en,
  input wire logic [31:0] call_ret_addr,
  input wire logic ip_wr_en,
  input wire logic [31:0] ip_next,
  input wire logic exc_push,
  input wire logic exc_pop,
  input wire logic mem_chk_en,
  input wire logic [31:0] mem_chk_addr,
  input wire crs_pkg::crs_size_t mem_chk_size,
  input wire logic [7:0] exc_vec_num,
  input wire logic [3:0] idx_base_idx,
  input wire logic [7:0] ip_disp,
  input wire logic ip_disp_long,
  output logic [31:0] idx_addr,
  output logic [31:0] gbr_idx_addr,
  output logic [31:0] vec_addr,
  output logic [31:0] ip_rel_addr,
  output logic [31:0] stack_addr,
  output logic addr_err,
  output logic [31:0] index_register_zero,
  output logic [31:0] hw_stack_pointer,
  output logic [31:0] processor_state_word,
  output logic [31:0] global_base,
  output logic [31:0] vector_table_base,
  output logic [31:0] mult_acc_high,
  output logic [31:0] mult_acc_low,
  output logic [31:0] return_link,
  output logic [31:0] instruction_pointer
);

  // ==========================================================
  // state
  typedef enum logic [1:0] {PH_BOOT, PH_STACK, PH_IP, PH_RUN} crs_phase_t;

  typedef struct packed {
    logic [15:0][31:0] gr;
    logic [31:0] state_word;
    logic [31:0] global_base;
    logic [31:0] vector_base;
    logic [31:0] mac_high;
    logic [31:0] mac_low;
    logic [31:0] return_link;
    logic [31:0] instr_ptr;
    crs_phase_t phase;
    logic vt_req;
    logic [31:0] vt_addr;
    logic run;
    logic [31:0] rd_a;
    logic [31:0] rd_b;
    logic [31:0] idx_addr;
    logic [31:0] gbr_idx_addr;
    logic [31:0] vec_addr;
    logic [31:0] ip_rel_addr;
    logic [31:0] stack_addr;
    logic addr_err;
    logic aerr_sticky;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } crs_state_t;

  crs_state_t s;
  crs_state_t next_s;
  logic [31:0] ext_wdata;
  logic align_err;
  logic chk_en;
  logic chk_stack;
  logic [31:0] chk_addr;
  logic [31:0] apb_rdata;
  logic apb_mapped;
  logic apb_write;

  // ==========================================================
  // extension and alignment unit
  // stack traffic borrows the checker, so it outranks other checks
  assign chk_stack = exc_push | exc_pop;
  assign chk_en = chk_stack | mem_chk_en;
  assign chk_addr = exc_push ? (s.gr[15] - crs_pkg::STACK_STEP) :
                    exc_pop ? s.gr[15] : mem_chk_addr;

  crs_operand_ext u_ext (
    .kind(gr_wr_kind),
    .size(gr_wr_size),
    .imm_op(gr_wr_imm_op),
    .data_in(gr_wr_data),
    .data_out(ext_wdata),
    .chk_en(chk_en),
    .chk_addr(chk_addr),
    .chk_size(mem_chk_size),
    .chk_stack(chk_stack),
    .align_err(align_err)
  );

  // ==========================================================
  // apb read decode; misaligned or unknown offsets answer slverr
  always_comb begin
    apb_rdata = 32'h0000_0000;
    apb_mapped = (paddr[1:0] == 2'h0);
    if (paddr[7:6] == crs_pkg::OFS_GR_BASE[7:6]) begin
      apb_rdata = s.gr[paddr[5:2]];
    end else begin
      case (paddr)
        crs_pkg::OFS_STATE_WORD: apb_rdata = s.state_word;
        crs_pkg::OFS_GLOBAL_BASE: apb_rdata = s.global_base;
        crs_pkg::OFS_VEC_BASE: apb_rdata = s.vector_base;
        crs_pkg::OFS_MAC_HIGH: apb_rdata = s.mac_high;
        crs_pkg::OFS_MAC_LOW: apb_rdata = s.mac_low;
        crs_pkg::OFS_RETURN_LINK: apb_rdata = s.return_link;
        crs_pkg::OFS_INSTR_PTR: apb_rdata = s.instr_ptr;
        crs_pkg::OFS_STATUS: begin
          apb_rdata[crs_pkg::STAT_RUN_BIT] = s.run;
          apb_rdata[crs_pkg::STAT_AERR_BIT] = s.aerr_sticky;
        end
        default: apb_mapped = 1'b0;
      endcase
    end
  end

  // a write lands only at the edge where pready is seen high
  assign apb_write = psel & penable & pwrite & s.pready & apb_mapped;

  // ==========================================================
  // next state; pipeline and boot writes land after apb, so they win
  always_comb begin
    next_s = s;
    // apb answers one cycle after psel rises
    next_s.pready = psel & ~s.pready;
    if (psel && !s.pready) begin
      // refused places read zero, even inside the general register span
      next_s.prdata = apb_mapped ? apb_rdata : 32'h0000_0000;
      next_s.pslverr = ~apb_mapped;
    end
    if (apb_write) begin
      if (paddr[7:6] == crs_pkg::OFS_GR_BASE[7:6]) begin
        next_s.gr[paddr[5:2]] = pwdata;
      end else begin
        case (paddr)
          crs_pkg::OFS_STATE_WORD:
            next_s.state_word = pwdata & crs_pkg::STATE_WRITABLE;
          crs_pkg::OFS_GLOBAL_BASE: next_s.global_base = pwdata;
          crs_pkg::OFS_VEC_BASE: next_s.vector_base = pwdata;
          crs_pkg::OFS_MAC_HIGH: next_s.mac_high = pwdata;
          crs_pkg::OFS_MAC_LOW: next_s.mac_low = pwdata;
          crs_pkg::OFS_RETURN_LINK: next_s.return_link = pwdata;
          crs_pkg::OFS_INSTR_PTR: next_s.instr_ptr = pwdata;
          crs_pkg::OFS_STATUS:
            if (pwdata[crs_pkg::STAT_AERR_BIT]) next_s.aerr_sticky = 1'b0;
          default: next_s.aerr_sticky = s.aerr_sticky;
        endcase
      end
    end

    // reset sequence: stack entry first, then instruction pointer
    unique case (s.phase)
      PH_BOOT: begin
        next_s.vt_req = 1'b1;
        next_s.vt_addr = s.vector_base + crs_pkg::VT_STACK_ENTRY;
        next_s.phase = PH_STACK;
      end
      PH_STACK: if (vt_ack) begin
        next_s.gr[15] = vt_data;
        next_s.vt_addr = s.vector_base + crs_pkg::VT_IP_ENTRY;
        next_s.phase = PH_IP;
      end
      PH_IP: if (vt_ack) begin
        next_s.instr_ptr = vt_data;
        next_s.vt_req = 1'b0;
        next_s.run = 1'b1;
        next_s.phase = PH_RUN;
      end
      PH_RUN: next_s.run = 1'b1;
    endcase

    // pipeline writes are only honoured once running
    if (s.run) begin
      if (gr_wr_en) begin
        next_s.gr[gr_wr_idx] = ext_wdata;
      end
      if (ctl_wr_en) begin
        unique case (ctl_wr_sel)
          crs_pkg::CS_STATE_WORD:
            next_s.state_word = ctl_wr_data & crs_pkg::STATE_WRITABLE;
          crs_pkg::CS_GLOBAL_BASE: next_s.global_base = ctl_wr_data;
          crs_pkg::CS_VEC_BASE: next_s.vector_base = ctl_wr_data;
          crs_pkg::CS_MAC_HIGH: next_s.mac_high = ctl_wr_data;
          crs_pkg::CS_MAC_LOW: next_s.mac_low = ctl_wr_data;
          crs_pkg::CS_RETURN_LINK: next_s.return_link = ctl_wr_data;
          crs_pkg::CS_INSTR_PTR: next_s.instr_ptr = ctl_wr_data;
          default: ; // unused selector code writes nothing
        endcase
      end
      if (mac_wr_en) begin
        next_s.mac_high = mac_high_data;
        next_s.mac_low = mac_low_data;
      end
      if (call_en) next_s.return_link = call_ret_addr;
      if (ip_wr_en) next_s.instr_ptr = ip_next;
      // push pre-decrements, pop post-increments
      if (exc_push) begin
        next_s.gr[15] = s.gr[15] - crs_pkg::STACK_STEP;
        next_s.stack_addr = s.gr[15] - crs_pkg::STACK_STEP;
      end else if (exc_pop) begin
        next_s.gr[15] = s.gr[15] + crs_pkg::STACK_STEP;
        next_s.stack_addr = s.gr[15];
      end
    end

    // read ports and address helpers, one cycle behind their inputs
    next_s.rd_a = s.gr[rd_a_idx];
    next_s.rd_b = s.gr[rd_b_idx];
    next_s.idx_addr = s.gr[idx_base_idx] + s.gr[0];
    next_s.gbr_idx_addr = s.global_base + s.gr[0];
    next_s.vec_addr = s.vector_base + {22'h00_0000, exc_vec_num, 2'h0};
    // longword tables are read from a longword-aligned base
    if (ip_disp_long) begin
      next_s.ip_rel_addr = {s.instr_ptr[31:2], 2'h0} + crs_pkg::IP_AHEAD
                         + {22'h00_0000, ip_disp, 2'h0};
    end else begin
      next_s.ip_rel_addr = s.instr_ptr + crs_pkg::IP_AHEAD
                         + {23'h00_0000, ip_disp, 1'h0};
    end

    // error pulse plus sticky copy; a new error beats the clear
    next_s.addr_err = align_err;
    if (align_err) next_s.aerr_sticky = 1'b1;
  end

  // ==========================================================
  // registers; ce low freezes everything, apb included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.state_word <= crs_pkg::STATE_RESET;
      s.vector_base <= crs_pkg::VEC_BASE_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs, straight from the state flops
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign vt_req = s.vt_req;
  assign vt_addr = s.vt_addr;
  assign run = s.run;
  assign rd_a_data = s.rd_a;
  assign rd_b_data = s.rd_b;
  assign idx_addr = s.idx_addr;
  assign gbr_idx_addr = s.gbr_idx_addr;
  assign vec_addr = s.vec_addr;
  assign ip_rel_addr = s.ip_rel_addr;
  assign stack_addr = s.stack_addr;
  assign addr_err = s.addr_err;
  assign index_register_zero = s.gr[0];
  assign hw_stack_pointer = s.gr[15];
  assign processor_state_word = s.state_word;
  assign global_base = s.global_base;
  assign vector_table_base = s.vector_base;
  assign mult_acc_high = s.mac_high;
  assign mult_acc_low = s.mac_low;
  assign return_link = s.return_link;
  assign instruction_pointer = s.instr_ptr;

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence stack_taken;
    ce && s.phase == PH_STACK && vt_ack;
  endsequence

  sequence ip_taken;
    ce && s.phase == PH_IP && vt_ack;
  endsequence

  boot_stack_load_a: assert property (
    stack_taken |=> hw_stack_pointer == $past(vt_data) && s.phase == PH_IP
      && vt_req && vt_addr == vector_table_base + crs_pkg::VT_IP_ENTRY)
    else $error("stack pointer not loaded from vector table");

  boot_ip_load_a: assert property (
    ip_taken |=> instruction_pointer == $past(vt_data) && run && !vt_req)
    else $error("instruction pointer not loaded or run not raised");

  reset_mask_a: assert property (
    s.phase == PH_BOOT |-> processor_state_word == crs_pkg::STATE_RESET)
    else $error("state word not at reset value");

  reserved_zero_a: assert property (
    (processor_state_word & ~crs_pkg::STATE_WRITABLE) == 32'h0000_0000)
    else $error("reserved state word bits not zero");

  load_sign_a: assert property (
    (ce && run && gr_wr_en && gr_wr_kind == crs_pkg::WK_LOAD
      && gr_wr_size == crs_pkg::SZ_WORD && !exc_push && !exc_pop)
    |=> s.gr[$past(gr_wr_idx)] == {{16{$past(gr_wr_data[15])}}, $past(gr_wr_data[15:0])})
    else $error("word load not sign extended");

  imm_sign_a: assert property (
    (ce && run && gr_wr_en && gr_wr_kind == crs_pkg::WK_IMM
      && gr_wr_imm_op == crs_pkg::IM_ADD && !exc_push && !exc_pop)
    |=> s.gr[$past(gr_wr_idx)] == {{24{$past(gr_wr_data[7])}}, $past(gr_wr_data[7:0])})
    else $error("add immediate not sign extended");

  imm_zero_a: assert property (
    (ce && run && gr_wr_en && gr_wr_kind == crs_pkg::WK_IMM
      && gr_wr_imm_op == crs_pkg::IM_AND && !exc_push && !exc_pop)
    |=> s.gr[$past(gr_wr_idx)][31:8] == 24'h00_0000)
    else $error("and immediate left upper bits set");

  word_align_a: assert property (
    (ce && mem_chk_en && !exc_push && !exc_pop
      && mem_chk_size == crs_pkg::SZ_WORD && mem_chk_addr[0]) |=> addr_err && s.aerr_sticky)
    else $error("odd word address not flagged");

  byte_free_a: assert property (
    (ce && mem_chk_en && !exc_push && !exc_pop && mem_chk_size == crs_pkg::SZ_BYTE)
    |=> !addr_err)
    else $error("byte access flagged as misaligned");

  stack_push_a: assert property (
    (ce && run && exc_push)
    |=> hw_stack_pointer == $past(hw_stack_pointer) - crs_pkg::STACK_STEP
      && stack_addr == hw_stack_pointer && addr_err == |stack_addr[1:0])
    else $error("stack push did not step the stack pointer");

  mac_write_a: assert property (
    (ce && run && mac_wr_en)
    |=> mult_acc_high == $past(mac_high_data) && mult_acc_low == $past(mac_low_data))
    else $error("multiply result not stored");

  ret_link_a: assert property (
    (ce && run && call_en) |=> return_link == $past(call_ret_addr))
    else $error("return address not stored");

endmodule

// ===== verif/crs_register_set_tb.sv
// self-checking bench of the processor register set
// assumes crs_vt_model as table memory and zero-wait apb answers
`timescale 1ns/1ps
module crs_register_set_tb;
  localparam logic [31:0] SP_INIT = 32'h0000_1ff0;
  localparam logic [31:0] IP_INIT = 32'h0000_0400;
  // ==========================================================
  // design signals, named as the ports so the instances connect by name
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, exc_vec_num = 8'h00, ip_disp = 8'h00;
  logic [3:0] rd_a_idx = 4'h0, rd_b_idx = 4'h0, gr_wr_idx = 4'h0, idx_base_idx = 4'h0;
  logic gr_wr_en = 1'b0, ctl_wr_en = 1'b0, mac_wr_en = 1'b0, call_en = 1'b0, ip_wr_en = 1'b0;
  logic exc_push = 1'b0, exc_pop = 1'b0, mem_chk_en = 1'b0, ip_disp_long = 1'b0;
  logic [31:0] pwdata = 32'h0, gr_wr_data = 32'h0, ctl_wr_data = 32'h0, mac_high_data = 32'h0;
  logic [31:0] mac_low_data = 32'h0, call_ret_addr = 32'h0, ip_next = 32'h0, mem_chk_addr = 32'h0;
  crs_pkg::crs_wkind_t gr_wr_kind = crs_pkg::WK_FULL;
  crs_pkg::crs_size_t gr_wr_size = crs_pkg::SZ_LONG, mem_chk_size = crs_pkg::SZ_BYTE;
  crs_pkg::crs_imm_op_t gr_wr_imm_op = crs_pkg::IM_MOVE;
  crs_pkg::crs_ctl_sel_t ctl_wr_sel = crs_pkg::CS_STATE_WORD;
  logic pready, pslverr, vt_req, vt_ack, run, addr_err;
  logic [31:0] prdata, vt_addr, vt_data, rd_a_data, rd_b_data, idx_addr, gbr_idx_addr, vec_addr;
  logic [31:0] ip_rel_addr, stack_addr, index_register_zero, hw_stack_pointer, global_base;
  logic [31:0] processor_state_word, vector_table_base, mult_acc_high, mult_acc_low;
  logic [31:0] return_link, instruction_pointer;
  logic [31:0] gr_m [16];
  logic [31:0] ctl_m [7];
  int n_mismatch = 0, comparisons = 0, cyc = 0;

  crs_register_set dut (.*);
  crs_vt_model #(.SP_INIT(SP_INIT), .IP_INIT(IP_INIT)) vt (.*);

  // clock and hang guard; the run needs well under 2000 cycles
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      results();
    end
  end

  // ==========================================================
  // compare, report and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one apb transfer; holds everything until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_mismatch++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // pipeline write, then read back on both ports
  task automatic gw(input logic [3:0] i, input crs_pkg::crs_wkind_t k, input crs_pkg::crs_size_t s,
                    input crs_pkg::crs_imm_op_t o, input logic [31:0] d, input logic [31:0] exp);
    @(posedge pclk);
    gr_wr_en <= 1'b1;
    gr_wr_idx <= i;
    gr_wr_kind <= k;
    gr_wr_size <= s;
    gr_wr_imm_op <= o;
    gr_wr_data <= d;
    @(posedge pclk);
    gr_wr_en <= 1'b0;
    rd_a_idx <= i;
    rd_b_idx <= i;
    gr_m[i] = exp;
    repeat (2) @(posedge pclk);
    #1;
    chk(rd_a_data, exp);
    chk(rd_b_data, exp);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] r, d, e32;
    logic e;
    int s;
    void'($urandom(32'hc1b2));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    e32 = 32'h0000_0000;
    e32[crs_pkg::MASK_MSB:crs_pkg::MASK_LSB] = 4'hf;
    apb(1'b0, crs_pkg::OFS_STATE_WORD, 32'h0, r, e);
    chk(r, e32);
    apb(1'b0, crs_pkg::OFS_VEC_BASE, 32'h0, r, e);
    chk(r, 32'h0000_0000);
    s = 0;
    while (run !== 1'b1 && s < 100) begin
      @(posedge pclk);
      s++;
    end
    chk(hw_stack_pointer, SP_INIT);
    chk(instruction_pointer, IP_INIT);
    chk({31'h0, run}, 32'h1);
    chk({31'h0, vt_req}, 32'h0);
    $display("test reset done");
    // every general register by software, then unmapped and misaligned places
    for (int i = 0; i < 16; i++) begin
      d = $urandom;
      if (i == 15) d[1:0] = 2'b00;
      gr_m[i] = d;
      apb(1'b1, 8'(i * 4), d, r, e);
    end
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, r, e);
      chk(r, gr_m[i]);
    end
    apb(1'b1, 8'h60, 32'hffff_ffff, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h41, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    $display("test registers done");
    // loads of each size, both signs; the sign extension is worked out here
    for (int j = 0; j < 6; j++) begin
      d = $urandom;
      d[7] = j[0];
      d[15] = j[0];
      e32 = (j % 3 == 0) ? {{24{d[7]}}, d[7:0]} : (j % 3 == 1) ? {{16{d[15]}}, d[15:0]} : d;
      gw(4'(j + 1), crs_pkg::WK_LOAD, crs_pkg::crs_size_t'(j % 3), crs_pkg::IM_MOVE, d, e32);
    end
    // every immediate kind with bit 7 set so sign and zero extension differ
    for (int j = 0; j < 7; j++) begin
      d = $urandom;
      d[7] = 1'b1;
      e32 = (j < 3) ? {24'hff_ffff, d[7:0]} : {24'h0, d[7:0]};
      gw(4'(j + 7), crs_pkg::WK_IMM, crs_pkg::SZ_BYTE, crs_pkg::crs_imm_op_t'(j), d, e32);
    end
    $display("test extension done");
    // alignment checks on random addresses of all three sizes
    for (int j = 0; j < 12; j++) begin
      d = $urandom;
      if (j == 1) d[0] = 1'b1;
      @(posedge pclk);
      mem_chk_en <= 1'b1;
      mem_chk_addr <= d;
      mem_chk_size <= crs_pkg::crs_size_t'(j % 3);
      @(posedge pclk);
      mem_chk_en <= 1'b0;
      #1;
      e = (j % 3 == 1) ? d[0] : (j % 3 == 2) ? (d[1:0] != 2'b00) : 1'b0;
      chk({31'h0, addr_err}, {31'h0, e});
    end
    // sticky error seen in status, then cleared by writing one
    e32 = 32'h0000_0000;
    e32[crs_pkg::STAT_RUN_BIT] = 1'b1;
    e32[crs_pkg::STAT_AERR_BIT] = 1'b1;
    apb(1'b0, crs_pkg::OFS_STATUS, 32'h0, r, e);
    chk(r, e32);
    apb(1'b1, crs_pkg::OFS_STATUS, e32, r, e);
    e32[crs_pkg::STAT_AERR_BIT] = 1'b0;
    apb(1'b0, crs_pkg::OFS_STATUS, 32'h0, r, e);
    chk(r, e32);
    $display("test alignment done");
    // control and system registers, back to back from the pipeline
    for (int j = 0; j < 7; j++) begin
      d = $urandom;
      ctl_m[j] = (j == 0) ? (d & crs_pkg::STATE_WRITABLE) : d;
      @(posedge pclk);
      ctl_wr_en <= 1'b1;
      ctl_wr_sel <= crs_pkg::crs_ctl_sel_t'(j);
      ctl_wr_data <= d;
    end
    @(posedge pclk);
    ctl_wr_en <= 1'b0;
    mac_wr_en <= 1'b1;
    mac_high_data <= d;
    mac_low_data <= ~d;
    call_en <= 1'b1;
    call_ret_addr <= d ^ 32'h5a5a_5a5a;
    idx_base_idx <= 4'h3;
    exc_vec_num <= 8'($urandom);
    ip_disp <= 8'($urandom);
    ip_disp_long <= 1'b1;
    @(posedge pclk);
    mac_wr_en <= 1'b0;
    call_en <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk(processor_state_word, ctl_m[0]);
    chk(global_base, ctl_m[1]);
    chk(vector_table_base, ctl_m[2]);
    chk(mult_acc_high, d);
    chk(mult_acc_low, ~d);
    chk(return_link, d ^ 32'h5a5a_5a5a);
    chk(index_register_zero, gr_m[0]);
    chk(idx_addr, gr_m[3] + gr_m[0]);
    chk(gbr_idx_addr, ctl_m[1] + gr_m[0]);
    chk(vec_addr, ctl_m[2] + {22'h0, exc_vec_num, 2'b00});
    chk(ip_rel_addr, (ctl_m[6] & ~32'h3) + 32'h4 + {22'h0, ip_disp, 2'b00});
    // word tables: new pointer from the pipeline, half-word displacement
    @(posedge pclk);
    ctl_m[6] = ctl_m[6] ^ 32'h0000_0002;
    ip_disp_long <= 1'b0;
    ip_wr_en <= 1'b1;
    ip_next <= ctl_m[6];
    @(posedge pclk);
    ip_wr_en <= 1'b0;
    @(posedge pclk);
    #1;
    chk(instruction_pointer, ctl_m[6]);
    chk(ip_rel_addr, ctl_m[6] + 32'h4 + {23'h0, ip_disp, 1'b0});
    // ce low freezes state: a write offered meanwhile must not land
    @(posedge pclk);
    ce <= 1'b0;
    ctl_wr_en <= 1'b1;
    ctl_wr_sel <= crs_pkg::CS_GLOBAL_BASE;
    ctl_wr_data <= ~ctl_m[1];
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    ctl_wr_en <= 1'b0;
    #1;
    chk(global_base, ctl_m[1]);
    // a stack push uses aligned longwords
    @(posedge pclk);
    exc_push <= 1'b1;
    @(posedge pclk);
    exc_push <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk({30'h0, stack_addr[1:0]}, 32'h0);
    chk(stack_addr, gr_m[15] - 32'h4);
    chk(hw_stack_pointer, gr_m[15] - 32'h4);
    // the pop reads the pushed word and steps back up
    @(posedge pclk);
    exc_pop <= 1'b1;
    @(posedge pclk);
    exc_pop <= 1'b0;
    #1;
    chk(stack_addr, gr_m[15] - 32'h4);
    chk(hw_stack_pointer, gr_m[15]);
    chk({31'h0, addr_err}, 32'h0);
    $display("test control done");
    results();
  end
endmodule

// ===== verif/crs_vt_model.sv
// vector table memory model answering the register set's reset reads
// assumes vt_req is held until acknowledged, one table word per ack
`timescale 1ns/1ps
module crs_vt_model #(
  parameter logic [31:0] SP_INIT = 32'h0000_1ff0,
  parameter logic [31:0] IP_INIT = 32'h0000_0400
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic vt_req,
  input wire logic [31:0] vt_addr,
  output logic vt_ack,
  output logic [31:0] vt_data
);
  // ==========================================================
  // table read
  // answer after 0..3 idle cycles so both prompt and slow paths run;
  // data is inverted outside an ack so nothing stale looks valid
  int wait_n;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vt_ack <= 1'b0;
      vt_data <= 32'h0000_0000;
      wait_n <= 2;
    end else if (vt_ack) begin
      vt_ack <= 1'b0;
      vt_data <= ~vt_data;
      wait_n <= $urandom % 4;
    end else if (vt_req && wait_n != 0) begin
      wait_n <= wait_n - 1;
    end else if (vt_req) begin
      vt_ack <= 1'b1;
      vt_data <= (vt_addr == crs_pkg::VT_STACK_ENTRY) ? SP_INIT : IP_INIT;
    end
  end
endmodule
